// [design/eqf_consts.vh]
`ifndef EQF_CONSTS_VH
`define EQF_CONSTS_VH
// ==========================================================
// Register byte offsets
`define EQF_OFS_CTRL 8'h00
`define EQF_OFS_TCLASS 8'h04
`define EQF_OFS_REGEN 8'h08
`define EQF_OFS_BUF_LIM 8'h0c
`define EQF_OFS_TRANSIT 8'h10
`define EQF_OFS_STATUS 8'h14
`define EQF_OFS_DROP_FULL 8'h18
`define EQF_OFS_DROP_AGE 8'h1c
// ==========================================================
// Control register fields
`define EQF_CTRL_NTC_LSB 0
`define EQF_CTRL_NTC_MSB 3
`define EQF_CTRL_RR 4
`define EQF_CTRL_AGE_EN 5
`define EQF_CTRL_ALT 6
// Status register fields
`define EQF_STAT_NONEMPTY_LSB 0
`define EQF_STAT_FWD 8
// ==========================================================
// Reset values
`define EQF_CTRL_RST 7'h00
`define EQF_REGEN_RST 24'hfac688
`define EQF_BUF_LIM_RST 16'h01f4
`define EQF_TRANSIT_RST 16'h03e8
// Recommended class tables, entry for priority p at bits 3p+2..3p
`define EQF_TC_DEF1 24'h000000
`define EQF_TC_DEF2 24'h249000
`define EQF_TC_DEF3 24'h489000
`define EQF_TC_DEF4 24'h6d2201
`define EQF_TC_DEF5 24'h91a201
`define EQF_TC_DEF6 24'hb63401
`define EQF_TC_DEF7 24'hd63401
`define EQF_TC_DEF8 24'hfac642
// Access priority maps, integrator supplied, plain defaults
`define EQF_ACC_MAP_RST 24'hfac688
`define EQF_ACC_ALT_RST 24'hd92000
// ==========================================================
// Outbound MAC methods
`define EQF_MAC_CSMA 3'h0
`define EQF_MAC_TBUS 3'h1
`define EQF_MAC_TRING 3'h2
`define EQF_MAC_DQDB 3'h3
`define EQF_MAC_ISLAN 3'h4
`define EQF_MAC_WLAN 3'h5
`define EQF_MAC_FDDI 3'h6
`define EQF_MAC_DPRI 3'h7
// Low access level for a method without priority support
`define EQF_ACC_LOW 3'h0
// ==========================================================
// Timing: age tick period in ns and clock period in ns
`define EQF_TICK_NS 1000
`define EQF_CLK_NS 40
`define EQF_TICK_CYC ((`EQF_TICK_NS) / (`EQF_CLK_NS))
`endif

// [design/eqf_class_fifo.v]
`timescale 1ns/1ps
// ==========================================================
// One traffic class queue: flip-flop ring, DEPTH a power of two
module eqf_class_fifo #(
  parameter W = 40,
  parameter DEPTH = 4,
  parameter AW = 2
)(
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Control
  input wire flush,
  input wire push,
  input wire [W-1:0] push_data,
  input wire pop,
  // State
  output wire [W-1:0] head,
  output wire empty,
  output wire full
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] rd_q;
  reg [AW-1:0] wr_q;
  reg [AW:0] cnt_q;
  wire do_push;
  wire do_pop;

  // Push refused when full; pop ignored when empty
  assign do_push = push && !full && !flush;
  assign do_pop = pop && !empty && !flush;
  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign full = (cnt_q == DEPTH[AW:0]);
  assign head = mem_q[rd_q];

  // Pointers and count; flush drops all entries at once
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= {AW{1'b0}};
      wr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      rd_q <= {AW{1'b0}};
      wr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      if (do_pop)
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      if (do_push && !do_pop)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage needs no reset; empty guards stale contents
  always @(posedge clock)
  begin
    if (do_push)
      mem_q[wr_q] <= push_data;
  end
endmodule

// [design/eqf_egress.v]
`timescale 1ns/1ps
`include "eqf_consts.vh"
// Function
// - Frames of one priority keep their arrival order through the port.
// - Class queue chosen by looking up the frame priority in the class table.
// - Up to eight classes; class 0 normal, nonzero classes expedited.
// - With a single class every priority maps to class 0.
// - Reset class table holds recommended entries for two to four classes.
// - Reset class table holds recommended entries for five to eight classes.
// - Frame leaves its queue when handed to the MAC, never retried.
// - Optionally drop frames whose buffering time has expired.
// - Drop frames that would exceed the transit delay limit.
// - Flush every queue when the port leaves forwarding.
// - Drops here touch only this port's copies.
// - Default selection is strict priority, highest nonempty class first.
// - Each queue is served oldest first.
// - Optional round-robin selection, order within queues unchanged.
// - Regenerated priority passed unchanged into the transmit request.
// - Access priority from a fixed per-method map, not software writable.
// - Token ring offers an alternate three-level map, default map otherwise.
// - Method without priority support gets the low access level.
// - Same LAN type and unmodified data reuses received check sequence.
// - Different type, modified data or bad check forces recalculation.
// - Invalid received check sequence marks the request field unspecified.
// - Class lookup uses the regenerated priority, identity by default.
module eqf_egress #(
  parameter NUM_TC = 8,
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter TAGW = 16,
  parameter [2:0] TX_MAC = `EQF_MAC_CSMA,
  parameter [23:0] ACC_MAP = `EQF_ACC_MAP_RST,
  parameter [23:0] ACC_ALT_MAP = `EQF_ACC_ALT_RST
)(
  // Clock and reset
  input wire clock,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Port state
  input wire port_fwd,
  // Relayed frames from the filtering stage
  input wire in_valid,
  input wire [TAGW-1:0] in_tag,
  input wire [2:0] in_prio,
  input wire [2:0] in_rx_mac,
  input wire in_modified,
  input wire in_fcs_ok,
  output reg in_ready,
  // Transmit request to the port MAC
  output reg tx_valid,
  input wire tx_ready,
  output reg [TAGW-1:0] tx_tag,
  output reg [2:0] tx_prio,
  output reg [2:0] tx_access,
  output reg tx_fcs_keep
);
  // ========================================================
  // Descriptor layout and derived constants
  localparam TSW = 16;
  localparam DW = TAGW + 4 + TSW;
  localparam P_LSB = TAGW;
  localparam K_BIT = TAGW + 3;
  localparam T_LSB = TAGW + 4;
  localparam [15:0] TICK_CYC = `EQF_TICK_CYC;
  localparam [3:0] NTC_MAX = NUM_TC;
  localparam [23:0] TC_DEF =
    (NUM_TC == 8) ? `EQF_TC_DEF8 : (NUM_TC == 7) ? `EQF_TC_DEF7 :
    (NUM_TC == 6) ? `EQF_TC_DEF6 : (NUM_TC == 5) ? `EQF_TC_DEF5 :
    (NUM_TC == 4) ? `EQF_TC_DEF4 : (NUM_TC == 3) ? `EQF_TC_DEF3 :
    (NUM_TC == 2) ? `EQF_TC_DEF2 : `EQF_TC_DEF1;

  // ========================================================
  // Registers
  reg [3:0] ntc_q;
  reg rr_en_q;
  reg age_en_q;
  reg alt_q;
  reg [23:0] tclass_q;
  reg [23:0] regen_q;
  reg [15:0] buf_lim_q;
  reg [15:0] transit_q;
  reg [15:0] drop_full_q;
  reg [15:0] drop_age_q;
  reg [15:0] pre_q;
  reg [TSW-1:0] now_q;
  reg [2:0] rr_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;

  integer i;
  integer k;
  wire [7:0] q_empty;
  wire [7:0] q_full;
  wire [7:0] q_push;
  wire [7:0] q_pop;
  wire [7:0] expired;
  wire [7:0] elig;
  wire load;
  wire [DW-1:0] q_head [0:7];
  reg [2:0] sel_c;
  reg sel_any;
  reg [2:0] j;
  reg [3:0] n_exp;
  integer m;

  // ========================================================
  // Arrival path: regenerate, classify, stamp
  wire [2:0] reg_prio;
  wire [2:0] tc_raw;
  wire [2:0] tc_in;
  wire [2:0] tc_top;
  wire keep_in;
  wire [DW-1:0] in_desc;
  wire arrive;

  assign reg_prio = regen_q[3*in_prio +: 3];
  assign tc_raw = tclass_q[3*reg_prio +: 3];
  assign tc_top = ntc_q[2:0] - 3'h1;
  // Class beyond the supported count folds onto the top class
  assign tc_in = (ntc_q == 4'h1) ? 3'h0 :
    ((tc_raw > tc_top) ? tc_top : tc_raw);
  // Received check sequence reusable only on a clean same-type relay
  assign keep_in = (in_rx_mac == TX_MAC) && !in_modified && in_fcs_ok;
  assign in_desc = {now_q, keep_in, reg_prio, in_tag};
  // Frames offered while the port is not forwarding are discarded
  assign arrive = in_valid && in_ready && port_fwd;

  // ========================================================
  // Class queues, one per supported class
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1)
    begin : g_cls
      wire [TSW-1:0] age;
      assign q_push[c] = arrive && (tc_in == c);
      if (c < NUM_TC)
      begin : g_on
        eqf_class_fifo #(.W(DW), .DEPTH(DEPTH), .AW(AW)) u_q (
          .clock(clock),
          .resetn(resetn),
          .flush(!port_fwd),
          .push(q_push[c]),
          .push_data(in_desc),
          .pop(q_pop[c]),
          .head(q_head[c]),
          .empty(q_empty[c]),
          .full(q_full[c])
        );
      end
      else
      begin : g_off
        assign q_head[c] = {DW{1'b0}};
        assign q_empty[c] = 1'b1;
        assign q_full[c] = 1'b1;
      end
      // Head is the oldest entry, so ageing only ever looks at it
      assign age = now_q - q_head[c][T_LSB +: TSW];
      assign expired[c] = !q_empty[c] &&
        (((transit_q != 16'h0000) && (age >= transit_q)) ||
         (age_en_q && (buf_lim_q != 16'h0000) && (age >= buf_lim_q)));
      assign elig[c] = !q_empty[c] && !expired[c] && (c < ntc_q);
      // Expired heads leave; selection never picks them
      assign q_pop[c] = expired[c] || (load && sel_any && (sel_c == c));
    end
  endgenerate

  // ========================================================
  // Selection: strict priority or round robin
  assign load = port_fwd && (!tx_valid || tx_ready);

  always @*
  begin
    sel_any = 1'b0;
    sel_c = 3'h0;
    j = 3'h0;
    if (!rr_en_q)
    begin
      // Later hits win, so the highest eligible class is taken
      for (i = 0; i < 8; i = i + 1)
        if (elig[i])
        begin
          sel_any = 1'b1;
          sel_c = i[2:0];
        end
    end
    else
    begin
      // Scan from far to near so the class after the last served wins
      for (k = 7; k >= 0; k = k - 1)
      begin
        j = rr_q + 3'h1 + k[2:0];
        if (elig[j])
        begin
          sel_any = 1'b1;
          sel_c = j;
        end
      end
    end
  end

  // Count queues aged out this cycle
  always @*
  begin
    n_exp = 4'h0;
    for (m = 0; m < 8; m = m + 1)
      n_exp = n_exp + {3'h0, expired[m]};
  end

  // ========================================================
  // Access priority from fixed maps
  wire [DW-1:0] sel_desc;
  wire [2:0] sel_prio;
  wire [2:0] acc;
  assign sel_desc = q_head[sel_c];
  assign sel_prio = sel_desc[P_LSB +: 3];
  // Maps are parameters; no register can reach them
  assign acc = (TX_MAC == `EQF_MAC_ISLAN) ? `EQF_ACC_LOW :
    ((TX_MAC == `EQF_MAC_TRING) && alt_q) ? ACC_ALT_MAP[3*sel_prio +: 3] :
    ACC_MAP[3*sel_prio +: 3];

  // Transmit stage; a loaded frame is already out of its queue
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_valid <= 1'b0;
      tx_tag <= {TAGW{1'b0}};
      tx_prio <= 3'h0;
      tx_access <= 3'h0;
      tx_fcs_keep <= 1'b0;
      rr_q <= 3'h0;
    end
    else if (!port_fwd)
      tx_valid <= 1'b0;
    else if (load)
    begin
      tx_valid <= sel_any;
      if (sel_any)
      begin
        tx_tag <= sel_desc[TAGW-1:0];
        tx_prio <= sel_prio;
        tx_access <= acc;
        tx_fcs_keep <= sel_desc[K_BIT];
        rr_q <= sel_c;
      end
    end
  end

  // ========================================================
  // Age time base and drop counters
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_q <= 16'h0000;
      now_q <= {TSW{1'b0}};
      drop_full_q <= 16'h0000;
      drop_age_q <= 16'h0000;
      in_ready <= 1'b0;
    end
    else
    begin
      // Always ready: a full queue drops rather than stalls the relay
      in_ready <= 1'b1;
      if (pre_q == TICK_CYC - 16'h0001)
      begin
        pre_q <= 16'h0000;
        now_q <= now_q + {{(TSW-1){1'b0}}, 1'b1};
      end
      else
        pre_q <= pre_q + 16'h0001;
      if (arrive && q_full[tc_in] && drop_full_q != 16'hffff)
        drop_full_q <= drop_full_q + 16'h0001;
      // Saturating; a wrap would hide a burst of losses
      if (n_exp != 4'h0)
      begin
        if ({1'b0, drop_age_q} + {13'h0, n_exp} > 17'h0ffff)
          drop_age_q <= 16'hffff;
        else
          drop_age_q <= drop_age_q + {12'h000, n_exp};
      end
    end
  end

  // ========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  wire ahb_go;
  wire [31:0] status;
  assign ahb_go = hsel && hready && htrans[1];
  assign status = {23'h0, port_fwd, ~q_empty};

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= ahb_go && hwrite;
      wr_addr_q <= haddr;
      if (ahb_go && !hwrite)
      begin
        case (haddr)
          `EQF_OFS_CTRL: hrdata <= {25'h0, alt_q, age_en_q, rr_en_q, ntc_q};
          `EQF_OFS_TCLASS: hrdata <= {8'h00, tclass_q};
          `EQF_OFS_REGEN: hrdata <= {8'h00, regen_q};
          `EQF_OFS_BUF_LIM: hrdata <= {16'h0000, buf_lim_q};
          `EQF_OFS_TRANSIT: hrdata <= {16'h0000, transit_q};
          `EQF_OFS_STATUS: hrdata <= status;
          `EQF_OFS_DROP_FULL: hrdata <= {16'h0000, drop_full_q};
          `EQF_OFS_DROP_AGE: hrdata <= {16'h0000, drop_age_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes land in the data phase
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ntc_q <= NTC_MAX;
      rr_en_q <= 1'b0;
      age_en_q <= 1'b0;
      alt_q <= 1'b0;
      tclass_q <= TC_DEF;
      regen_q <= `EQF_REGEN_RST;
      buf_lim_q <= `EQF_BUF_LIM_RST;
      transit_q <= `EQF_TRANSIT_RST;
    end
    else if (wr_pend_q)
    begin
      case (wr_addr_q)
        `EQF_OFS_CTRL:
        begin
          // Class count clamped to what was built
          if (hwdata[`EQF_CTRL_NTC_MSB:`EQF_CTRL_NTC_LSB] == 4'h0)
            ntc_q <= 4'h1;
          else if (hwdata[`EQF_CTRL_NTC_MSB:`EQF_CTRL_NTC_LSB] > NTC_MAX)
            ntc_q <= NTC_MAX;
          else
            ntc_q <= hwdata[`EQF_CTRL_NTC_MSB:`EQF_CTRL_NTC_LSB];
          rr_en_q <= hwdata[`EQF_CTRL_RR];
          age_en_q <= hwdata[`EQF_CTRL_AGE_EN];
          alt_q <= hwdata[`EQF_CTRL_ALT];
        end
        `EQF_OFS_TCLASS: tclass_q <= hwdata[23:0];
        `EQF_OFS_REGEN: regen_q <= hwdata[23:0];
        `EQF_OFS_BUF_LIM: buf_lim_q <= hwdata[15:0];
        `EQF_OFS_TRANSIT: transit_q <= hwdata[15:0];
        default: ntc_q <= ntc_q;
      endcase
    end
  end
endmodule

// [tb/eqf_egress_props.sv]
`timescale 1ns/1ps
`include "eqf_consts.vh"
// ==========================================================
// Port-level checks of the egress queue
module eqf_egress_props #(
  parameter TAGW = 16,
  parameter [2:0] TX_MAC = `EQF_MAC_CSMA,
  parameter [23:0] ACC_MAP = `EQF_ACC_MAP_RST
)(
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // Arrivals
  input wire port_fwd,
  input wire in_valid,
  input wire [TAGW-1:0] in_tag,
  input wire [2:0] in_rx_mac,
  input wire in_modified,
  input wire in_fcs_ok,
  input wire in_ready,
  // Transmit request
  input wire tx_valid,
  input wire tx_ready,
  input wire [TAGW-1:0] tx_tag,
  input wire [2:0] tx_prio,
  input wire [2:0] tx_access,
  input wire tx_fcs_keep
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire take = in_valid && in_ready && port_fwd;
  wire give = tx_valid && tx_ready;
  reg [7:0] pend_q;
  reg keep1_q;
  reg keep2_q;
  // Frames in flight; drops overcount it, so a flush resyncs it to zero
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_q <= 8'h00;
      keep1_q <= 1'b0;
      keep2_q <= 1'b0;
    end
    else
    begin
      keep1_q <= (in_rx_mac == TX_MAC) && !in_modified && in_fcs_ok;
      keep2_q <= keep1_q;
      if (!port_fwd)
        pend_q <= 8'h00;
      else if (take && !give)
        pend_q <= pend_q + 8'h01;
      else if (give && !take)
        pend_q <= pend_q - 8'h01;
    end
  end
  sequence s_take_idle;
    take && !tx_valid && pend_q == 8'h00 ##1 port_fwd;
  endsequence
  sequence s_wait;
    tx_valid && !tx_ready && port_fwd;
  endsequence
  property p_hold;
    s_wait |=> tx_valid && $stable(tx_tag) && $stable(tx_prio);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before acceptance");
  property p_no_retry;
    give |=> !tx_valid || tx_tag != $past(tx_tag);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("frame offered again");
  property p_no_invent;
    give && port_fwd |-> pend_q != 8'h00;
  endproperty
  a_no_invent: assert property (p_no_invent) else $error("frame sent never queued");
  property p_flush;
    !port_fwd |=> !tx_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("request kept while not forwarding");
  property p_rise;
    $rose(tx_valid) |-> $past(port_fwd);
  endproperty
  a_rise: assert property (p_rise) else $error("request raised while not forwarding");
  property p_idle;
    s_take_idle |=> tx_valid && tx_tag == $past(in_tag, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("idle port did not offer frame");
  property p_fcs;
    s_take_idle |=> tx_fcs_keep == keep2_q;
  endproperty
  a_fcs: assert property (p_fcs) else $error("check sequence reuse wrong");
  property p_access;
    TX_MAC != 3'h4 && TX_MAC != 3'h2 && tx_valid |-> tx_access == ACC_MAP[3*tx_prio +: 3];
  endproperty
  a_access: assert property (p_access) else $error("access level wrong");
  property p_ready;
    resetn && $past(resetn) |-> in_ready && hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("arrivals or bus stalled");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus error response");
endmodule

bind eqf_egress eqf_egress_props #(.TAGW(TAGW), .TX_MAC(TX_MAC), .ACC_MAP(ACC_MAP)) i_props (
  .clock(clock), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp), .port_fwd(port_fwd),
  .in_valid(in_valid), .in_tag(in_tag), .in_rx_mac(in_rx_mac), .in_modified(in_modified),
  .in_fcs_ok(in_fcs_ok), .in_ready(in_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_tag(tx_tag), .tx_prio(tx_prio), .tx_access(tx_access), .tx_fcs_keep(tx_fcs_keep));

// [tb/eqf_mac_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Port MAC transmit entity: accepts requests and logs them
module eqf_mac_model (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Bench control
  input wire stall,
  input wire clear,
  // Transmit request
  input wire tx_valid,
  output reg tx_ready,
  input wire [15:0] tx_tag,
  input wire [2:0] tx_prio,
  input wire [2:0] tx_access,
  input wire tx_fcs_keep
);
  reg [15:0] tag_log [0:15];
  reg [6:0] info_log [0:15];
  integer n_got;
  // Ready is registered, so a stall shows one edge later
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ready <= 1'b0;
      n_got <= 0;
    end
    else
    begin
      tx_ready <= !stall;
      if (clear)
        n_got <= 0;
      else if (tx_valid && tx_ready && n_got < 16)
      begin
        tag_log[n_got] <= tx_tag;
        // Keep flag is logged above access level and priority; no check sequence is built
        info_log[n_got] <= {tx_fcs_keep, tx_access, tx_prio};
        n_got <= n_got + 1;
      end
    end
  end
endmodule

// [tb/bridge_egress_priority_queuing_test.sv]
`timescale 1ns/1ps
`include "eqf_consts.vh"
// ==========================================================
// Egress queue bench
module bridge_egress_priority_queuing_test;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h00000000;
  reg port_fwd = 1'b1;
  reg in_valid = 1'b0;
  reg [15:0] in_tag = 16'h0000;
  reg [2:0] in_prio = 3'h0;
  reg [2:0] in_rx_mac = 3'h0;
  reg in_modified = 1'b0;
  reg in_fcs_ok = 1'b1;
  reg stall = 1'b0;
  reg clear = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, in_ready, tx_valid, tx_ready, tx_fcs_keep;
  wire [15:0] tx_tag;
  wire [2:0] tx_prio, tx_access;
  integer n_fail = 0;
  integer checks = 0;
  integer i;
  reg [31:0] q;
  reg [2:0] rp;
  // Per-frame stimulus of the check-sequence scenario, frame 0 lowest
  localparam [11:0] pr = {3'h5, 3'h7, 3'h3, 3'h0};
  localparam [11:0] mc = {3'h0, 3'h0, 3'h1, 3'h0};
  localparam [3:0] md = 4'b0100;
  localparam [3:0] ok = 4'b0111;
  localparam [31:0] rg = 32'h06543217;
  localparam [23:0] acc_map = `EQF_ACC_MAP_RST;

  always #20 clock = ~clock;

  eqf_egress #(.DEPTH(4), .AW(2)) i_dut (
    .clock(clock), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_fwd(port_fwd), .in_valid(in_valid),
    .in_tag(in_tag), .in_prio(in_prio), .in_rx_mac(in_rx_mac), .in_modified(in_modified),
    .in_fcs_ok(in_fcs_ok), .in_ready(in_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_tag(tx_tag), .tx_prio(tx_prio), .tx_access(tx_access), .tx_fcs_keep(tx_fcs_keep));

  eqf_mac_model i_mac (
    .clock(clock), .resetn(resetn), .stall(stall), .clear(clear), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_tag(tx_tag), .tx_prio(tx_prio), .tx_access(tx_access),
    .tx_fcs_keep(tx_fcs_keep));

  // ==========================================================
  // Tasks
  task close_out;
  begin
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task chk(input string what, input [31:0] exp, input [31:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // Single transfer; each phase ends at an edge that samples hready high
  task ahb(input wr, input [7:0] a, input [31:0] d);
    integer ph;
    integer k;
  begin
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    for (ph = 0; ph < 2; ph = ph + 1)
    begin
      k = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1 && k < 40)
      begin
        @(posedge clock);
        k = k + 1;
      end
      if (k == 40)
      begin
        n_fail = n_fail + 1;
        close_out;
      end
      if (ph == 0)
      begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    q = hrdata;
  end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task rdc(input [7:0] a, input [31:0] exp);
  begin
    ahb(1'b0, a, 32'h00000000);
    chk("register", exp, q);
  end
  endtask

  // Pack eight nibble entries into the 3-bit table layout
  function [31:0] pack(input [31:0] nib);
    integer k;
  begin
    pack = 32'h00000000;
    for (k = 0; k < 8; k = k + 1)
      pack[3*k +: 3] = nib[4*k +: 3];
  end
  endfunction

  // One descriptor; in_ready never drops, so it is taken at the next edge
  task send(input [15:0] t, input [2:0] p, input [2:0] m, input mo, input fo);
  begin
    in_tag <= t;
    in_prio <= p;
    in_rx_mac <= m;
    in_modified <= mo;
    in_fcs_ok <= fo;
    in_valid <= 1'b1;
    @(posedge clock);
    in_valid <= 1'b0;
    @(posedge clock);
  end
  endtask

  task start(input st);
  begin
    clear <= 1'b1;
    stall <= st;
    @(posedge clock);
    clear <= 1'b0;
  end
  endtask

  // Let the MAC drain, then compare count and order of tags
  task expect_tags(input integer n, input [31:0] tags);
    integer k;
  begin
    stall <= 1'b0;
    k = 0;
    while (i_mac.n_got < n && k < 400)
    begin
      @(posedge clock);
      k = k + 1;
    end
    if (k == 400)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
    repeat (8) @(posedge clock);
    chk("frames sent", n, i_mac.n_got);
    for (k = 0; k < n; k = k + 1)
      chk("tag order", {28'h0, tags[4*k +: 4]}, {16'h0, i_mac.tag_log[k]});
  end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    // Reset values, a write to a read-only place, an unmapped read
    rdc(`EQF_OFS_CTRL, 32'h8);
    rdc(`EQF_OFS_TCLASS, pack(32'h76543102));
    rdc(`EQF_OFS_REGEN, pack(32'h76543210));
    rdc(`EQF_OFS_BUF_LIM, 32'h1f4);
    rdc(`EQF_OFS_TRANSIT, 32'h3e8);
    wr(`EQF_OFS_STATUS, 32'hffffffff);
    rdc(`EQF_OFS_STATUS, 32'h100);
    rdc(8'h20, 32'h0);
    $display("test registers done");
    // Stalled MAC: highest class first, oldest first within a class
    start(1'b1);
    send(1, 1, 0, 0, 1);
    send(2, 1, 0, 0, 1);
    send(3, 0, 0, 0, 1);
    send(4, 2, 0, 0, 1);
    send(5, 7, 0, 0, 1);
    expect_tags(5, 32'h24351);
    $display("test strict priority done");
    // Regenerated priority, access level and check-sequence reuse
    wr(`EQF_OFS_REGEN, pack(rg));
    start(1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      send(i[15:0] + 16'h1, pr[3*i +: 3], mc[3*i +: 3], md[i], ok[i]);
      @(posedge clock);
    end
    expect_tags(4, 32'h4321);
    for (i = 0; i < 4; i = i + 1)
    begin
      rp = rg[4*pr[3*i +: 3] +: 3];
      chk("tx info", {25'h0, mc[3*i +: 3] == 3'h0 && !md[i] && ok[i], acc_map[3*rp +: 3], rp},
        {25'h0, i_mac.info_log[i]});
    end
    $display("test mapping done");
    // One class: a single oldest-first queue, overflow dropped
    wr(`EQF_OFS_CTRL, 32'h1);
    start(1'b1);
    for (i = 1; i < 8; i = i + 1)
      send(i[15:0], 3'h7 - i[2:0], 0, 0, 1);
    expect_tags(5, 32'h54321);
    rdc(`EQF_OFS_DROP_FULL, 32'h2);
    $display("test single class done");
    // Transit limit, then buffering limit, drop a waiting frame
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(`EQF_OFS_TRANSIT, i == 0 ? 32'h4 : 32'h0);
      wr(`EQF_OFS_BUF_LIM, 32'h4);
      wr(`EQF_OFS_CTRL, i == 0 ? 32'h8 : 32'h28);
      start(1'b1);
      send(1, 3, 0, 0, 1);
      send(2, 3, 0, 0, 1);
      repeat (200) @(posedge clock);
      expect_tags(1, 32'h1);
      rdc(`EQF_OFS_DROP_AGE, i + 1);
    end
    $display("test ageing done");
    // Round robin: the class after the last served goes next, ageing off
    wr(`EQF_OFS_CTRL, 32'h18);
    start(1'b1);
    send(1, 3, 0, 0, 1);
    send(2, 1, 0, 0, 1);
    send(3, 5, 0, 0, 1);
    send(4, 4, 0, 0, 1);
    send(5, 3, 0, 0, 1);
    expect_tags(5, 32'h52341);
    $display("test round robin done");
    // Leaving forwarding empties the port and ignores arrivals
    start(1'b1);
    send(1, 7, 0, 0, 1);
    send(2, 0, 0, 0, 1);
    rdc(`EQF_OFS_STATUS, 32'h180);
    port_fwd <= 1'b0;
    send(3, 7, 0, 0, 1);
    port_fwd <= 1'b1;
    rdc(`EQF_OFS_STATUS, 32'h100);
    expect_tags(0, 32'h0);
    $display("test flush done");
    close_out;
  end
endmodule
